/* design/hcir_pkg.sv */
// Purpose: shared constants of the host cpu interface register set
// Assumes: byte offsets, one aligned 32-bit word per register
// Notes: masks keep reserved bits at zero inside the register cells
package hcir_pkg;
   localparam int HCIR_NREG = 21;
   localparam int HCIR_DW = 32;
   localparam int HCIR_AW = 8;
   localparam int HCIR_IW = 5;
   // direct fifo port address
   localparam logic [7:0] HCIR_FIFO_ADDR = 8'hff;
   // byte offsets, index order follows the register map
   localparam logic [7:0] HCIR_OFF [HCIR_NREG] = '{
      8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
      8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34,
      8'h38, 8'h3c, 8'h40, 8'h44, 8'h48, 8'h4c, 8'h50};
   // implemented bits of each register
   localparam logic [31:0] HCIR_MASK [HCIR_NREG] = '{
      32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
      32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
      32'hffffffff, 32'h0000000f, 32'h00000007, 32'hffffffff,
      32'hffffffff, 32'h000000ff, 32'h0000ffff, 32'h0000ffff,
      32'h000000ff, 32'hffffffff, 32'hffffffff, 32'h000000ff,
      32'h00000003};
   // bit i set: register i written by the host processor
   localparam logic [HCIR_NREG-1:0] HCIR_HOSTW = 21'h1c0545;
   // bit i set: register i used in host mode only
   localparam logic [HCIR_NREG-1:0] HCIR_HOSTONLY = 21'h0ffec4;
   localparam logic [31:0] HCIR_RESET = 32'h00000000;
   // register indices used by the logic
   localparam logic [4:0] IDX_COMMAND = 5'h00;
   localparam logic [4:0] IDX_CMD_TAG = 5'h02;
   localparam logic [4:0] IDX_TARGET = 5'h06;
   localparam logic [4:0] IDX_ENDPOINT = 5'h08;
   localparam logic [4:0] IDX_USB_EP = 5'h09;
   localparam logic [4:0] IDX_PKT_KIND = 5'h0a;
   localparam logic [4:0] IDX_PROTOCOL = 5'h0d;
   localparam logic [4:0] IDX_MAKER = 5'h0e;
   localparam logic [4:0] IDX_PART = 5'h0f;
   localparam logic [4:0] IDX_HUB_ADDR = 5'h10;
   localparam logic [4:0] IDX_PKT_SIZE = 5'h12;
   localparam logic [4:0] IDX_RETRY = 5'h13;
   localparam logic [4:0] IDX_XFR_MODE = 5'h14;
   // packet kind field codes
   typedef enum logic [2:0] {
      toggle_unspecified = 3'h0,
      toggle_zero = 3'h1,
      toggle_one = 3'h2,
      setup_kind = 3'h3
   } hcir_kind_t;
   // transfer mode field codes
   localparam logic [1:0] HCIR_MODE_DMA = 2'h1;
   localparam logic [1:0] HCIR_MODE_FIFO = 2'h2;
   // control pin vector positions after synchronising
   localparam int CP_CS = 0;
   localparam int CP_RD = 1;
   localparam int CP_WR = 2;
   localparam int CP_ACK = 3;
   localparam int CP_CLKSEL = 4;
   localparam int CP_W = 5;
endpackage

/* design/hcir_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: each bit is an independent level
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
module hcir_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] sync
);
   logic [W-1:0] meta_q;
   // double flop against metastability
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= INIT;
         sync <= INIT;
      end else begin
         meta_q <= pin;
         sync <= meta_q;
      end
   end
endmodule

/* design/hcir_regcell.sv */
// Purpose: one 32-bit interface register with a single writer
// Assumes: both write strobes are one-cycle pulses on ref_clk
// Notes: reserved bits are masked off and always read zero
`timescale 1ns/100ps
module hcir_regcell
   import hcir_pkg::*;
#(
   parameter logic [31:0] MASK = 32'hffffffff,
   parameter bit HOSTW = 1'b1
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic host_we,
   input wire logic usb_we,
   input wire logic [31:0] host_wdata,
   input wire logic [31:0] usb_wdata,
   output logic [31:0] value_q
);
   logic [31:0] value_d;
   // only the owning processor may change the cell
   assign value_d = HOSTW ? (host_wdata & MASK)
                          : (usb_wdata & MASK);
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         value_q <= HCIR_RESET;
      end else if (HOSTW ? host_we : usb_we) begin
         value_q <= value_d;
      end
   end
endmodule

/* design/hcir_regs.sv */
// Purpose: host cpu interface register set with fifo and dma port
// Assumes: host pins asynchronous to ref_clk, strobes held >= 4 clocks
// Notes: usb processor side runs on ref_clk and needs no crossing
//
// Summary of operation
// - registers are 32 bits, word aligned
// - reads without permission return zero
// - writes without permission are ignored
// - memory mapped, 32-bit data, 8-bit address
// - dma slave via request and acknowledge
// - usb-written registers are read-only to host
// - 21 registers from 0x00 to 0x50
// - host-only registers apply in host mode
// - endpoint number in bits 3:0
// - packet kind codes zero, one, setup
// - code 00 means toggle tracked internally
// - protocol code in bits 7:0
// - maker and part ids in bits 15:0
// - hub address in bits 7:0
// - retry count low byte per transaction
// - registers read zero after reset
// - clock select high uses crystal input clock
// - transfer mode 01 dma, 02 direct fifo
// - address 0xff is the direct fifo port
`timescale 1ns/100ps
module hcir_regs
   import hcir_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [hcir_pkg::HCIR_AW-1:0] host_addr,
   input wire logic [hcir_pkg::HCIR_DW-1:0] host_data_in,
   output logic [hcir_pkg::HCIR_DW-1:0] host_data_out,
   output logic host_data_oe_n,
   input wire logic host_cs_n,
   input wire logic host_rd_n,
   input wire logic host_wr_n,
   output logic dma_req,
   input wire logic dma_ack_n,
   input wire logic clk_sel,
   output logic clk_from_crystal,
   input wire logic host_mode,
   input wire logic usb_wr,
   input wire logic [hcir_pkg::HCIR_IW-1:0] usb_idx,
   input wire logic [hcir_pkg::HCIR_DW-1:0] usb_wdata,
   output logic fifo_push,
   output logic fifo_pop,
   output logic [hcir_pkg::HCIR_DW-1:0] fifo_wdata,
   input wire logic [hcir_pkg::HCIR_DW-1:0] fifo_rdata,
   input wire logic fifo_ready,
   input wire logic txn_done,
   output logic data_toggle,
   output logic cmd_issued,
   output logic [31:0] host_command,
   output logic [31:0] host_command_tag,
   output logic [31:0] host_target_address,
   output logic [3:0] host_endpoint_number,
   output logic [2:0] packet_kind,
   output logic [31:0] packet_size,
   output logic [7:0] retry_limit,
   output logic [1:0] transfer_mode_select
);
   import hcir_pkg::*;

   logic [CP_W-1:0] ctl_s;
   logic [CP_W-1:0] ctl_p_q;
   logic [HCIR_AW-1:0] addr_s;
   logic [HCIR_DW-1:0] wdat_s;
   logic [31:0] regs [HCIR_NREG];
   logic [HCIR_NREG-1:0] hit;
   logic [HCIR_NREG-1:0] perm;
   logic [31:0] rd_chain [HCIR_NREG+1];
   logic sel_n;
   logic rd_low;
   logic wr_fall;
   logic rd_fall;
   logic dma_on;
   logic fifo_sel;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [31:0] fdata_q;
   logic push_q;
   logic pop_q;
   logic req_q;
   logic cmd_q;
   logic tog_q;
   logic tog_d;
   logic tgl_out_q;
   logic tgl_out_d;
   logic strap_q;
   logic strap_done_q;
   logic [1:0] strap_wait_q;
   logic [2:0] kind;
   logic [1:0] mode;

   // pin inputs cross into ref_clk before any decode
   hcir_sync #(.W(CP_W), .INIT(5'h0f)) u_sync_ctl (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin({clk_sel, dma_ack_n, host_wr_n, host_rd_n, host_cs_n}),
      .sync(ctl_s)
   );

   hcir_sync #(.W(HCIR_AW + HCIR_DW), .INIT(40'h0)) u_sync_bus (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin({host_addr, host_data_in}),
      .sync({addr_s, wdat_s})
   );

   // previous synchronised value for edge detection
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctl_p_q <= 5'h0f;
      end else begin
         ctl_p_q <= ctl_s;
      end
   end

   // strobe decode; dma acknowledge overrides address decode
   assign sel_n = ctl_s[CP_CS];
   assign dma_on = ~ctl_s[CP_ACK];
   assign wr_fall = ~ctl_s[CP_WR] & ctl_p_q[CP_WR] & ~sel_n;
   assign rd_fall = ~ctl_s[CP_RD] & ctl_p_q[CP_RD] & ~sel_n;
   assign rd_low = ~ctl_s[CP_RD] & ~sel_n;
   assign fifo_sel = dma_on | (addr_s == HCIR_FIFO_ADDR);
   assign reg_wr = wr_fall & ~fifo_sel;
   assign reg_rd = rd_fall & ~fifo_sel;

   // one decoded cell per register, offsets from the map
   genvar gi;
   generate
      for (gi = 0; gi < HCIR_NREG; gi++) begin : g_reg
         assign hit[gi] = (addr_s == HCIR_OFF[gi]);
         // host-only registers vanish in function mode
         assign perm[gi] = host_mode | ~HCIR_HOSTONLY[gi];
         assign rd_chain[gi+1] = rd_chain[gi] |
            ((hit[gi] & perm[gi]) ? regs[gi] : 32'h0);
         hcir_regcell #(
            .MASK(HCIR_MASK[gi]),
            .HOSTW(HCIR_HOSTW[gi])
         ) u_cell (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .host_we(reg_wr & hit[gi] & perm[gi]),
            .usb_we(usb_wr & (usb_idx == 5'(gi))),
            .host_wdata(wdat_s),
            .usb_wdata(usb_wdata),
            .value_q(regs[gi])
         );
      end
   endgenerate
   assign rd_chain[0] = 32'h0;

   // read data: fifo word or decoded register, zero otherwise
   assign rdata_d = fifo_sel ? fifo_rdata : rd_chain[HCIR_NREG];

   // read capture and fifo strobes
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 32'h0;
         fdata_q <= 32'h0;
         push_q <= 1'b0;
         pop_q <= 1'b0;
      end else begin
         if (rd_fall) begin
            rdata_q <= rdata_d;
         end
         if (wr_fall & fifo_sel) begin
            fdata_q <= wdat_s;
         end
         push_q <= wr_fall & fifo_sel;
         pop_q <= rd_fall & fifo_sel;
      end
   end

   // data pins driven while chip select and read are low
   assign host_data_out = rdata_q;
   assign host_data_oe_n = ~rd_low;
   assign fifo_push = push_q;
   assign fifo_pop = pop_q;
   assign fifo_wdata = fdata_q;

   // field views of the host-written registers
   assign kind = regs[IDX_PKT_KIND][2:0];
   assign mode = regs[IDX_XFR_MODE][1:0];
   assign host_command = regs[IDX_COMMAND];
   assign host_command_tag = regs[IDX_CMD_TAG];
   assign host_target_address = regs[IDX_TARGET];
   assign host_endpoint_number = regs[IDX_ENDPOINT][3:0];
   assign packet_kind = kind;
   assign packet_size = regs[IDX_PKT_SIZE];
   assign retry_limit = regs[IDX_RETRY][7:0];
   assign transfer_mode_select = mode;

   // dma request only in dma mode; dropped during acknowledge
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         req_q <= 1'b0;
      end else begin
         req_q <= (mode == HCIR_MODE_DMA) & fifo_ready
                  & ~dma_on;
      end
   end
   assign dma_req = req_q;

   // pulse telling the engine a new command was written
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_q <= 1'b0;
      end else begin
         cmd_q <= reg_wr & hit[IDX_COMMAND];
      end
   end
   assign cmd_issued = cmd_q;

   // tracked toggle follows each completed transaction;
   // an explicit code reseeds it so the next packet alternates
   always_comb begin
      tog_d = tog_q;
      tgl_out_d = tog_q;
      case (kind)
         toggle_unspecified: begin
            tgl_out_d = tog_q;
            if (txn_done) begin
               tog_d = ~tog_q;
            end
         end
         toggle_zero: begin
            tgl_out_d = 1'b0;
            if (txn_done) begin
               tog_d = 1'b1;
            end
         end
         toggle_one: begin
            tgl_out_d = 1'b1;
            if (txn_done) begin
               tog_d = 1'b0;
            end
         end
         setup_kind: begin
            tgl_out_d = 1'b0;
            if (txn_done) begin
               tog_d = 1'b1;
            end
         end
         default: begin
            tgl_out_d = tog_q;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tog_q <= 1'b0;
         tgl_out_q <= 1'b0;
      end else begin
         tog_q <= tog_d;
         tgl_out_q <= tgl_out_d;
      end
   end
   assign data_toggle = tgl_out_q;

   // clock source strap caught once after reset release; the sync
   // flops sit in reset too, so wait until the pin has passed them;
   // the analogue clock mux itself sits outside this block
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         strap_q <= 1'b0;
         strap_done_q <= 1'b0;
         strap_wait_q <= 2'h0;
      end else if (!strap_done_q) begin
         strap_wait_q <= {strap_wait_q[0], 1'b1};
         strap_q <= ctl_s[CP_CLKSEL];
         strap_done_q <= strap_wait_q[1];
      end
   end
   assign clk_from_crystal = strap_q;

   // checks next to the logic they guard
   a_unmapped_zero: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_rd & ~|(hit & perm)) |=> (host_data_out == 32'h0))
      else $error("unmapped read returned nonzero data");

   a_ro_write_kept: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_wr & hit[IDX_HUB_ADDR] & ~usb_wr)
      |=> $stable(regs[IDX_HUB_ADDR]))
      else $error("host write changed a usb-written register");

   a_usb_ep_mask: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      regs[IDX_USB_EP][31:4] == 28'h0)
      else $error("endpoint reserved bits not zero");

   a_usb_write_lands: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (usb_wr & (usb_idx == IDX_PROTOCOL))
      |=> (regs[IDX_PROTOCOL] == ($past(usb_wdata) & 32'hff)))
      else $error("usb write to protocol code lost");

   a_id_width: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (regs[IDX_MAKER][31:16] == 16'h0) &&
      (regs[IDX_PART][31:16] == 16'h0))
      else $error("identifier upper bits not zero");

   a_fifo_push: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (wr_fall & (addr_s == HCIR_FIFO_ADDR))
      |=> (fifo_push && fifo_wdata == $past(wdat_s)) ##1 !fifo_push)
      else $error("direct fifo write did not push once");

   a_fifo_pop: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (rd_fall & (addr_s == HCIR_FIFO_ADDR))
      |=> fifo_pop && (host_data_out == $past(fifo_rdata)))
      else $error("direct fifo read did not pop");

   a_dma_mode: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      dma_req |-> ($past(mode) == HCIR_MODE_DMA) && $past(fifo_ready))
      else $error("dma request outside dma mode");

   a_toggle_track: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (kind == toggle_unspecified && txn_done && !usb_wr
       && !reg_wr) ##1 (kind == toggle_unspecified)
      |-> ##1 (data_toggle != $past(data_toggle)))
      else $error("internal toggle did not advance");

   a_func_hidden: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_rd & hit[IDX_RETRY] & ~host_mode)
      |=> (host_data_out == 32'h0))
      else $error("host-only register visible in function mode");

   a_retry_read: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_wr & hit[IDX_RETRY] & host_mode)
      |=> (retry_limit == $past(wdat_s[7:0])))
      else $error("retry count not taken");

   a_strap_hold: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      $past(strap_done_q) |-> $stable(clk_from_crystal))
      else $error("clock source changed after reset");
endmodule

/* tb/hcir_host_model.sv */
// Purpose: system processor and dma controller driving the register pins
// Assumes: pins change only at falling edges of ref_clk
// Notes: addr goes to the inverse of its last value once released
`timescale 1ns/100ps
module hcir_host_model (
   input wire logic ref_clk,
   output logic [7:0] addr,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic ack_n,
   output logic [31:0] wdata,
   output logic drive,
   input wire logic [31:0] bus
);
   // idle pins: all strobes high, bus released
   initial begin
      addr = 8'h00;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      ack_n = 1'b1;
      wdata = 32'h0;
      drive = 1'b0;
   end

   // one strobe; generous margins since the pins pass two sync flops
   task automatic access(input logic wr, input logic dma,
         input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(negedge ref_clk);
      addr = a;
      wdata = d;
      drive = wr;
      cs_n = 1'b0;
      ack_n = ~dma;
      repeat (3) @(negedge ref_clk);
      if (wr) wr_n = 1'b0;
      else rd_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      q = bus;
      wr_n = 1'b1;
      rd_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      cs_n = 1'b1;
      ack_n = 1'b1;
      drive = 1'b0;
      addr = ~a;
      repeat (2) @(negedge ref_clk);
   endtask
endmodule

/* tb/host_cpu_interface_register_set_tb.sv */
// Purpose: self-checking bench for the host cpu interface register set
// Assumes: host pins come from hcir_host_model at falling edges
// Notes: expectations are built from the register map constants
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
$display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module host_cpu_interface_register_set_tb;
   import hcir_pkg::*;
   logic ref_clk, sys_rst, clk_sel, host_mode, usb_wr, fifo_ready;
   logic txn_done, ack_n, cs_n, rd_n, wr_n, drive, oe_n, dma_req;
   logic clk_from_crystal, fifo_push, fifo_pop, data_toggle, cmd_issued;
   logic [4:0] usb_idx;
   logic [7:0] addr, retry_limit;
   logic [31:0] usb_wdata, wdata, dout, fifo_wdata, fifo_rdata, q;
   logic [31:0] host_command, last_push;
   logic [31:0] cmd_tag, tgt_addr, pkt_size;
   logic [3:0] ep_num;
   logic [2:0] pkt_kind;
   logic [1:0] xfr_mode;
   logic [31:0] junk = 32'h0;
   int miscompares = 0, checked = 0, n_push = 0, n_pop = 0, n_cmd = 0;
   wire [31:0] bus;

   // released bus shows junk, which stays at zero since negating zero gives zero
   assign bus = (oe_n === 1'b0) ? dout : (drive ? wdata : junk);

   hcir_host_model host (.ref_clk(ref_clk), .addr(addr), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .ack_n(ack_n), .wdata(wdata),
      .drive(drive), .bus(bus));

   hcir_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .host_addr(addr),
      .host_data_in(bus), .host_data_out(dout), .host_data_oe_n(oe_n),
      .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n),
      .dma_req(dma_req), .dma_ack_n(ack_n), .clk_sel(clk_sel),
      .clk_from_crystal(clk_from_crystal), .host_mode(host_mode),
      .usb_wr(usb_wr), .usb_idx(usb_idx), .usb_wdata(usb_wdata),
      .fifo_push(fifo_push), .fifo_pop(fifo_pop), .fifo_wdata(fifo_wdata),
      .fifo_rdata(fifo_rdata), .fifo_ready(fifo_ready),
      .txn_done(txn_done), .data_toggle(data_toggle),
      .cmd_issued(cmd_issued), .host_command(host_command),
      .host_command_tag(cmd_tag), .host_target_address(tgt_addr),
      .host_endpoint_number(ep_num), .packet_kind(pkt_kind),
      .packet_size(pkt_size),
      .retry_limit(retry_limit), .transfer_mode_select(xfr_mode));

   // 20 MHz reference clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // pulse counters; pulses last one cycle so they are counted here
   always @(posedge ref_clk) begin
      junk <= ~junk + 32'h1;
      if (fifo_push === 1'b1) n_push++;
      if (fifo_push === 1'b1) last_push = fifo_wdata;
      if (fifo_pop === 1'b1) n_pop++;
      if (cmd_issued === 1'b1) n_cmd++;
   end

   function automatic logic [31:0] pat(input int i);
      return 32'h8d2b4c71 ^ (32'(i) * 32'h01101011);
   endfunction

   // host regs hold pat, usb regs its inverse, hidden ones read zero
   function automatic logic [31:0] expv(input int i);
      if (!host_mode && HCIR_HOSTW[i] !== 1'bx && HCIR_HOSTONLY[i])
         return 32'h0;
      return (HCIR_HOSTW[i] ? pat(i) : ~pat(i)) & HCIR_MASK[i];
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      host.access(1'b1, 1'b0, a, d, unused);
   endtask

   task automatic rd(input logic [7:0] a);
      host.access(1'b0, 1'b0, a, 32'h0, q);
   endtask

   task automatic do_reset;
      @(negedge ref_clk);
      sys_rst = 1'b1;
      repeat (5) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask

   task automatic chk_all;
      for (int i = 0; i < HCIR_NREG; i++) begin
         rd(HCIR_OFF[i]);
         `CHK(q, expv(i))
      end
   endtask

   // back-to-back usb writes of the inverse pattern to every index
   task automatic usb_all;
      for (int i = 0; i < HCIR_NREG; i++) begin
         @(negedge ref_clk);
         usb_wr = 1'b1;
         usb_idx = 5'(i);
         usb_wdata = ~pat(i);
      end
      @(negedge ref_clk);
      usb_wr = 1'b0;
   endtask

   task automatic t_reset_values;
      for (int i = 0; i < HCIR_NREG; i++) begin
         rd(HCIR_OFF[i]);
         `CHK(q, 32'h0)
      end
      `CHK(clk_from_crystal, 1'b0)
   endtask

   task automatic t_permissions;
      int c;
      usb_all();
      c = n_cmd;
      for (int i = 0; i < HCIR_NREG; i++)
         wr(HCIR_OFF[i], HCIR_HOSTW[i] ? pat(i) & HCIR_MASK[i] : pat(i));
      chk_all();
      `CHK(n_cmd, c + 1)
      `CHK(retry_limit, 8'(expv(19)))
      `CHK(host_command, expv(0))
      `CHK(cmd_tag, expv(2))
      `CHK(tgt_addr, expv(6))
      `CHK(ep_num, 4'(expv(8)))
      `CHK(pkt_kind, 3'(expv(10)))
      `CHK(pkt_size, expv(18))
      `CHK(xfr_mode, 2'(expv(20)))
      usb_all();
      chk_all();
   endtask

   // host-only places vanish in function mode and ignore writes
   task automatic t_function_mode;
      host_mode = 1'b0;
      wr(HCIR_OFF[IDX_RETRY], 32'h000000aa);
      chk_all();
      host_mode = 1'b1;
      rd(HCIR_OFF[IDX_RETRY]);
      `CHK(q, expv(19))
   endtask

   task automatic t_refused;
      rd(8'h54);
      `CHK(q, 32'h0)
      rd(8'h4e);
      `CHK(q, 32'h0)
      wr(8'h4d, 32'h00000005);
      rd(HCIR_OFF[IDX_RETRY]);
      `CHK(q, expv(19))
   endtask

   task automatic t_toggle;
      logic [2:0] kinds [5] = '{toggle_zero, toggle_one, setup_kind,
         toggle_unspecified, toggle_unspecified};
      logic tog [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      for (int k = 0; k < 5; k++) begin
         wr(HCIR_OFF[IDX_PKT_KIND], {29'h0, kinds[k]});
         @(negedge ref_clk);
         txn_done = 1'b1;
         @(negedge ref_clk);
         txn_done = 1'b0;
         @(negedge ref_clk);
         `CHK(data_toggle, tog[k])
      end
   endtask

   task automatic t_fifo_dma;
      int p;
      p = n_push;
      wr(HCIR_FIFO_ADDR, 32'h0badf1f0);
      `CHK(n_push, p + 1)
      `CHK(last_push, 32'h0badf1f0)
      p = n_pop;
      rd(HCIR_FIFO_ADDR);
      `CHK(q, 32'h3c5a96e1)
      `CHK(n_pop, p + 1)
      wr(HCIR_OFF[IDX_XFR_MODE], {30'h0, HCIR_MODE_DMA});
      fifo_ready = 1'b1;
      repeat (3) @(negedge ref_clk);
      `CHK(dma_req, 1'b1)
      p = n_push;
      host.access(1'b1, 1'b1, 8'h00, 32'h600dcafe, q);
      `CHK(n_push, p + 1)
      `CHK(host_command, expv(0))
      wr(HCIR_OFF[IDX_XFR_MODE], {30'h0, HCIR_MODE_FIFO});
      repeat (3) @(negedge ref_clk);
      `CHK(dma_req, 1'b0)
      fifo_ready = 1'b0;
   endtask

   // strap is set one cycle before reset; the strap logic waits for the sync flops after release
   task automatic t_clock_source;
      clk_sel = 1'b1;
      do_reset();
      `CHK(clk_from_crystal, 1'b1)
      rd(HCIR_OFF[IDX_RETRY]);
      `CHK(q, 32'h0)
   endtask

   task automatic tally_and_finish;
      if (miscompares == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      sys_rst = 1'b1;
      clk_sel = 1'b0;
      host_mode = 1'b1;
      usb_wr = 1'b0;
      usb_idx = 5'h00;
      usb_wdata = 32'h0;
      fifo_ready = 1'b0;
      txn_done = 1'b0;
      fifo_rdata = 32'h3c5a96e1;
      do_reset();
      t_reset_values();
      t_permissions();
      t_function_mode();
      t_refused();
      t_toggle();
      t_fifo_dma();
      t_clock_source();
      tally_and_finish();
   end

   // the run needs about 1900 cycles; this cuts a hang short
   initial begin
      #1000000;
      miscompares++;
      tally_and_finish();
   end
endmodule
